// file: pkg/lsc_pkg.sv
// Constants shared by the light sensor control logic: register map,
// field positions, reset values, bus address and timing counts.
// Assumes a 25 MHz system clock and 8-bit registers.
package lsc_pkg;
  // Target address and register offsets.
  localparam logic [6:0] TARGET_ADDR = 7'h39;
  localparam logic [7:0] OFS_FUNCTION_ENABLE = 8'h80;
  localparam logic [7:0] OFS_INTEGRATION_TIME = 8'h81;
  localparam logic [7:0] OFS_WAIT_TIME = 8'h83;
  localparam logic [7:0] OFS_LOW_THRESHOLD_LO = 8'h84;
  localparam logic [7:0] OFS_LOW_THRESHOLD_HI = 8'h85;
  localparam logic [7:0] OFS_HIGH_THRESHOLD_LO = 8'h86;
  localparam logic [7:0] OFS_HIGH_THRESHOLD_HI = 8'h87;
  localparam logic [7:0] OFS_INTERRUPT_PERSISTENCE = 8'h8C;
  localparam logic [7:0] OFS_CONFIG_ZERO = 8'h8D;
  localparam logic [7:0] OFS_CONFIG_ONE = 8'h90;
  localparam logic [7:0] OFS_REVISION_CODE = 8'h91;
  localparam logic [7:0] OFS_PART_CODE = 8'h92;
  localparam logic [7:0] OFS_DEVICE_STATUS = 8'h93;
  localparam logic [7:0] OFS_VISIBLE_RESULT_LO = 8'h94;
  localparam logic [7:0] OFS_VISIBLE_RESULT_HI = 8'h95;
  localparam logic [7:0] OFS_INFRARED_RESULT_LO = 8'h96;
  localparam logic [7:0] OFS_INFRARED_RESULT_HI = 8'h97;
  localparam logic [7:0] OFS_AUXILIARY_CODE = 8'h9E;
  localparam logic [7:0] OFS_CONFIG_TWO = 8'h9F;
  localparam logic [7:0] OFS_CONFIG_THREE = 8'hAB;
  localparam logic [7:0] OFS_AUTOZERO_CONFIG = 8'hD6;
  localparam logic [7:0] OFS_INTERRUPT_ENABLES = 8'hDD;
  // Reset values.
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_CONFIG_ZERO = 8'h80;
  localparam logic [7:0] RST_CONFIG_TWO = 8'h04;
  localparam logic [7:0] RST_CONFIG_THREE = 8'h0C;
  localparam logic [7:0] RST_AUTOZERO_CONFIG = 8'h7F;
  // Identity codes; the values are arbitrary.
  localparam logic [7:0] REVISION_VALUE = 8'h01;
  localparam logic [7:0] PART_VALUE = 8'h02;
  localparam logic [7:0] AUXILIARY_VALUE = 8'h03;
  // Enable register bit positions.
  localparam int POWER_ON_BIT = 0;
  localparam int MEASURE_ENABLE_BIT = 1;
  localparam int WAIT_ENABLE_BIT = 3;
  // Status bit positions and the sleep-after-interrupt bit in config one.
  localparam int STATUS_IRQ_BIT = 4;
  localparam int SLEEP_AFTER_IRQ_BIT = 4;
  localparam int GAIN_LSB = 0;
  // Integration timing: one step is 2048 integration clocks, and the
  // integration clock is the oscillator divided by 11.
  localparam int OSC_DIVIDE = 11;
  localparam int STEP_INT_CLOCKS = 2048;
  localparam real OSC_MHZ = 8.107;
  localparam real SYS_MHZ = 25.0;
  localparam real STEP_MS = 2.78;
  localparam int STEP_CYCLES = int'(STEP_MS * SYS_MHZ * 1000.0);
  // System states.
  typedef enum logic [4:0] {
    LSC_SLEEP = 5'b00001,
    LSC_IDLE = 5'b00010,
    LSC_AUTOZERO = 5'b00100,
    LSC_INTEGRATE = 5'b01000,
    LSC_WAIT = 5'b10000
  } lsc_state_t;
  // Serial engine states.
  typedef enum logic [3:0] {
    LSC_BUS_IDLE = 4'b0001,
    LSC_BUS_RX = 4'b0010,
    LSC_BUS_ACK = 4'b0100,
    LSC_BUS_TX = 4'b1000
  } lsc_bus_t;
endpackage

// file: rtl/lsc_top.sv
// Light sensor control: I2C target with retained pointer, register file
// and the Sleep/Idle/integration/Wait state machine.
// Assumes SCL and SDA inputs are already synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module lsc_top
  import lsc_pkg::*;
#(
  parameter int STEP_LEN = lsc_pkg::STEP_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [15:0] visible_sample,
  input wire logic [15:0] infrared_sample,
  input wire logic irq_event,
  output logic [2:0] analog_gain,
  output logic integrating,
  output logic [4:0] system_state
);
  import lsc_pkg::*;

  // ==========================================================
  // Bus edge and condition detection
  // ==========================================================
  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  // Previous pin levels; inputs are already synchronous.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else if (clk_en)
    begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  // Conditions are edges of data while the clock stays high.
  assign scl_rise = scl_in & ~scl_q;
  assign scl_fall = ~scl_in & scl_q;
  assign start_cond = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_cond = scl_in & scl_q & ~sda_q & sda_in;

  // ==========================================================
  // Serial engine
  // ==========================================================
  lsc_bus_t bus_state;
  logic [7:0] shifter;
  logic [3:0] bit_cnt;
  logic [1:0] byte_idx;
  logic reading;
  logic selected;
  logic [7:0] pointer;
  logic [7:0] rd_data;
  logic wr_strobe;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic master_nack;

  // The engine samples on SCL rising and changes SDA on SCL falling, so
  // any clock rate far below sys_clk works the same way.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      bus_state <= LSC_BUS_IDLE;
      shifter <= RST_ZERO;
      bit_cnt <= 4'h0;
      byte_idx <= 2'h0;
      reading <= 1'b0;
      selected <= 1'b0;
      pointer <= RST_ZERO;
      sda_out <= 1'b1;
      sda_oe <= 1'b0;
      wr_strobe <= 1'b0;
      wr_addr <= RST_ZERO;
      wr_data <= RST_ZERO;
      master_nack <= 1'b0;
    end
    else if (clk_en)
    begin
      wr_strobe <= 1'b0;
      if (start_cond)
      begin
        bus_state <= LSC_BUS_RX;
        bit_cnt <= 4'h0;
        byte_idx <= 2'h0;
        selected <= 1'b0;
        sda_oe <= 1'b0;
      end
      else if (stop_cond)
      begin
        // The pointer is left as it is for the next transaction.
        bus_state <= LSC_BUS_IDLE;
        sda_oe <= 1'b0;
      end
      else
      begin
        unique case (bus_state)
          LSC_BUS_IDLE:
          begin
            sda_oe <= 1'b0;
          end
          LSC_BUS_RX:
          begin
            if (scl_rise)
            begin
              shifter <= {shifter[6:0], sda_in};
              bit_cnt <= bit_cnt + 4'h1;
            end
            else if (scl_fall && bit_cnt == 4'h8)
            begin
              bit_cnt <= 4'h0;
              bus_state <= LSC_BUS_ACK;
              if (byte_idx == 2'h0)
              begin
                // Only our own address is acknowledged.
                if (shifter[7:1] == TARGET_ADDR)
                begin
                  selected <= 1'b1;
                  reading <= shifter[0];
                  sda_out <= 1'b0;
                  sda_oe <= 1'b1;
                end
                else
                begin
                  bus_state <= LSC_BUS_IDLE;
                end
              end
              else
              begin
                sda_out <= 1'b0;
                sda_oe <= 1'b1;
                if (byte_idx == 2'h1)
                begin
                  pointer <= shifter;
                end
                else
                begin
                  // Every written byte is acknowledged, mapped or not.
                  wr_strobe <= 1'b1;
                  wr_addr <= pointer;
                  wr_data <= shifter;
                  pointer <= pointer + 8'h01;
                end
              end
              if (byte_idx != 2'h2)
              begin
                byte_idx <= byte_idx + 2'h1;
              end
            end
          end
          LSC_BUS_ACK:
          begin
            if (scl_fall)
            begin
              if (reading && selected)
              begin
                // Reads start at the retained pointer.
                sda_out <= rd_data[7];
                sda_oe <= ~rd_data[7];
                shifter <= rd_data;
                pointer <= pointer + 8'h01;
                bus_state <= LSC_BUS_TX;
              end
              else
              begin
                sda_oe <= 1'b0;
                bus_state <= LSC_BUS_RX;
              end
            end
          end
          LSC_BUS_TX:
          begin
            if (scl_rise && bit_cnt == 4'h8)
            begin
              master_nack <= sda_in;
            end
            if (scl_rise)
            begin
              bit_cnt <= bit_cnt + 4'h1;
            end
            else if (scl_fall)
            begin
              if (bit_cnt == 4'h8)
              begin
                sda_oe <= 1'b0;
              end
              else if (bit_cnt == 4'h9)
              begin
                bit_cnt <= 4'h0;
                if (master_nack)
                begin
                  // Not-acknowledge ends the read; wait for STOP.
                  bus_state <= LSC_BUS_IDLE;
                end
                else
                begin
                  sda_out <= rd_data[7];
                  sda_oe <= ~rd_data[7];
                  shifter <= rd_data;
                  pointer <= pointer + 8'h01;
                end
              end
              else
              begin
                // Open drain: only a low is driven.
                sda_out <= shifter[6];
                sda_oe <= ~shifter[6];
                shifter <= {shifter[6:0], 1'b0};
              end
            end
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Register file
  // ==========================================================
  logic [7:0] function_enable;
  logic [7:0] integration_time;
  logic [7:0] wait_time;
  logic [7:0] low_threshold_lo;
  logic [7:0] low_threshold_hi;
  logic [7:0] high_threshold_lo;
  logic [7:0] high_threshold_hi;
  logic [7:0] interrupt_persistence;
  logic [7:0] config_zero;
  logic [7:0] config_one;
  logic [7:0] config_two;
  logic [7:0] config_three;
  logic [7:0] autozero_config;
  logic [7:0] interrupt_enables;
  logic [7:0] device_status;
  logic [15:0] visible_result;
  logic [15:0] infrared_result;
  logic autozero_done_flag;
  logic status_wr;

  // Writable registers; a status write clears the interrupt flag, anything else is dropped silently.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      function_enable <= RST_ZERO;
      integration_time <= RST_ZERO;
      wait_time <= RST_ZERO;
      low_threshold_lo <= RST_ZERO;
      low_threshold_hi <= RST_ZERO;
      high_threshold_lo <= RST_ZERO;
      high_threshold_hi <= RST_ZERO;
      interrupt_persistence <= RST_ZERO;
      config_zero <= RST_CONFIG_ZERO;
      config_one <= RST_ZERO;
      config_two <= RST_CONFIG_TWO;
      config_three <= RST_CONFIG_THREE;
      autozero_config <= RST_AUTOZERO_CONFIG;
      interrupt_enables <= RST_ZERO;
    end
    else if (clk_en && wr_strobe)
    begin
      unique case (wr_addr)
        OFS_FUNCTION_ENABLE: function_enable <= wr_data;
        OFS_INTEGRATION_TIME: integration_time <= wr_data;
        OFS_WAIT_TIME: wait_time <= wr_data;
        OFS_LOW_THRESHOLD_LO: low_threshold_lo <= wr_data;
        OFS_LOW_THRESHOLD_HI: low_threshold_hi <= wr_data;
        OFS_HIGH_THRESHOLD_LO: high_threshold_lo <= wr_data;
        OFS_HIGH_THRESHOLD_HI: high_threshold_hi <= wr_data;
        OFS_INTERRUPT_PERSISTENCE: interrupt_persistence <= wr_data;
        OFS_CONFIG_ZERO: config_zero <= wr_data;
        OFS_CONFIG_ONE: config_one <= wr_data;
        OFS_CONFIG_TWO: config_two <= wr_data;
        OFS_CONFIG_THREE: config_three <= wr_data;
        OFS_AUTOZERO_CONFIG: autozero_config <= wr_data;
        OFS_INTERRUPT_ENABLES: interrupt_enables <= wr_data;
        default: ;
      endcase
    end
  end

  // Read mux for the byte at the pointer.
  always_comb
  begin
    unique case (pointer)
      OFS_FUNCTION_ENABLE: rd_data = function_enable;
      OFS_INTEGRATION_TIME: rd_data = integration_time;
      OFS_WAIT_TIME: rd_data = wait_time;
      OFS_LOW_THRESHOLD_LO: rd_data = low_threshold_lo;
      OFS_LOW_THRESHOLD_HI: rd_data = low_threshold_hi;
      OFS_HIGH_THRESHOLD_LO: rd_data = high_threshold_lo;
      OFS_HIGH_THRESHOLD_HI: rd_data = high_threshold_hi;
      OFS_INTERRUPT_PERSISTENCE: rd_data = interrupt_persistence;
      OFS_CONFIG_ZERO: rd_data = config_zero;
      OFS_CONFIG_ONE: rd_data = config_one;
      OFS_REVISION_CODE: rd_data = REVISION_VALUE;
      OFS_PART_CODE: rd_data = PART_VALUE;
      OFS_DEVICE_STATUS: rd_data = device_status;
      OFS_VISIBLE_RESULT_LO: rd_data = visible_result[7:0];
      OFS_VISIBLE_RESULT_HI: rd_data = visible_result[15:8];
      OFS_INFRARED_RESULT_LO: rd_data = infrared_result[7:0];
      OFS_INFRARED_RESULT_HI: rd_data = infrared_result[15:8];
      OFS_AUXILIARY_CODE: rd_data = AUXILIARY_VALUE;
      OFS_CONFIG_TWO: rd_data = config_two;
      OFS_CONFIG_THREE: rd_data = config_three;
      OFS_AUTOZERO_CONFIG: rd_data = autozero_config;
      OFS_INTERRUPT_ENABLES: rd_data = interrupt_enables;
      default: rd_data = RST_ZERO;
    endcase
  end

  // Gain code drives the front end; codes span 1x to 128x.
  assign analog_gain = config_one[GAIN_LSB +: 3];
  assign status_wr = wr_strobe && wr_addr == OFS_DEVICE_STATUS;

  // ==========================================================
  // System state machine
  // ==========================================================
  lsc_state_t state;
  logic [8:0] step_left;
  logic [31:0] tick_cnt;
  logic step_tick;
  logic power_on;
  logic measure_on;
  logic irq_flag;

  assign power_on = function_enable[POWER_ON_BIT];
  assign measure_on = function_enable[MEASURE_ENABLE_BIT];
  assign irq_flag = device_status[STATUS_IRQ_BIT];
  // One step is one STEP_LEN count of sys_clk.
  assign step_tick = tick_cnt == STEP_LEN - 1;

  // Step timer runs only while integrating or waiting.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      tick_cnt <= 32'h0;
    end
    else if (clk_en)
    begin
      if (step_tick || !(state == LSC_INTEGRATE || state == LSC_WAIT))
      begin
        tick_cnt <= 32'h0;
      end
      else
      begin
        tick_cnt <= tick_cnt + 32'h1;
      end
    end
  end

  // Sequencing of Sleep, Idle, autozero, integration and Wait.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state <= LSC_SLEEP;
      step_left <= 9'h0;
      visible_result <= 16'h0000;
      infrared_result <= 16'h0000;
    end
    else if (clk_en)
    begin
      unique case (state)
        LSC_SLEEP:
        begin
          if (power_on && !(config_one[SLEEP_AFTER_IRQ_BIT] && irq_flag))
          begin
            state <= LSC_IDLE;
          end
        end
        LSC_IDLE:
        begin
          if (!power_on)
          begin
            state <= LSC_SLEEP;
          end
          else if (measure_on)
          begin
            state <= LSC_AUTOZERO;
          end
        end
        LSC_AUTOZERO:
        begin
          if (!power_on || !measure_on)
          begin
            state <= LSC_IDLE;
          end
          else if (autozero_done_flag)
          begin
            state <= LSC_INTEGRATE;
            step_left <= {1'b0, integration_time} + 9'h1;
          end
        end
        LSC_INTEGRATE:
        begin
          if (!power_on || !measure_on)
          begin
            state <= LSC_IDLE;
          end
          else if (step_tick && step_left == 9'h1)
          begin
            // Both channels latch together.
            visible_result <= visible_sample;
            infrared_result <= infrared_sample;
            state <= LSC_WAIT;
            step_left <= {1'b0, wait_time} + 9'h1;
          end
          else if (step_tick)
          begin
            step_left <= step_left - 9'h1;
          end
        end
        LSC_WAIT:
        begin
          if (!power_on || !measure_on)
          begin
            state <= LSC_IDLE;
          end
          else if (config_one[SLEEP_AFTER_IRQ_BIT] && irq_flag)
          begin
            state <= LSC_SLEEP;
          end
          else if (!function_enable[WAIT_ENABLE_BIT] ||
                   (step_tick && step_left == 9'h1))
          begin
            state <= LSC_AUTOZERO;
          end
          else if (step_tick)
          begin
            step_left <= step_left - 9'h1;
          end
        end
      endcase
    end
  end

  // Autozero-done is set by the calibration pass and cleared by any
  // nonzero write to the autozero register, in every state.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      autozero_done_flag <= 1'b0;
    end
    else if (clk_en)
    begin
      if (wr_strobe && wr_addr == OFS_AUTOZERO_CONFIG && wr_data != RST_ZERO)
      begin
        autozero_done_flag <= 1'b0;
      end
      else if (state == LSC_AUTOZERO)
      begin
        autozero_done_flag <= 1'b1;
      end
    end
  end

  // Interrupt flag: set at the end of integration when irq_event is high,
  // cleared by any status write; a set in the same cycle wins.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      device_status <= RST_ZERO;
    end
    else if (clk_en)
    begin
      if (state == LSC_INTEGRATE && step_tick && step_left == 9'h1 &&
          irq_event)
      begin
        device_status[STATUS_IRQ_BIT] <= 1'b1;
      end
      else if (status_wr)
      begin
        device_status[STATUS_IRQ_BIT] <= 1'b0;
      end
    end
  end

  assign integrating = state == LSC_INTEGRATE;
  assign system_state = state;
endmodule // lsc_top
`default_nettype wire

// file: tb/lsc_top_chk.sv
// Port checker for the light sensor control top.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module lsc_top_chk
  import lsc_pkg::*;
#(
  parameter int STEP_LEN = 4
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [15:0] visible_sample,
  input wire logic [15:0] infrared_sample,
  input wire logic irq_event,
  input wire logic [2:0] analog_gain,
  input wire logic integrating,
  input wire logic [4:0] system_state
);
  logic [31:0] run_len;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // ========================================
  // Integration length
  // Counts integrating cycles so whole steps can be checked at the end.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      run_len <= '0;
    else if (clk_en)
      run_len <= integrating ? run_len + 32'h1 : '0;
  end
  sequence s_integ_end;
    $fell(integrating) ##0 (system_state == LSC_WAIT);
  endsequence
  // ========================================
  // Properties
  a_reset_to_sleep: assert property ($fell(rst) |->
    system_state == LSC_SLEEP && !sda_oe) else $error("no sleep after reset");
  a_integ_whole_steps: assert property (s_integ_end |->
    run_len != 0 && run_len % STEP_LEN == 0) else $error("integration length");
  a_wait_after_integ: assert property ($rose(system_state == LSC_WAIT) |->
    $past(system_state) == LSC_INTEGRATE) else $error("wait out of order");
  a_sleep_exit_idle: assert property (system_state == LSC_SLEEP |=>
    system_state inside {LSC_SLEEP, LSC_IDLE}) else $error("bad sleep exit");
  a_integ_exit_order: assert property (integrating |=>
    integrating || system_state inside {LSC_WAIT, LSC_IDLE})
    else $error("integration left out of order");
  a_sda_quiet_high: assert property (scl_in && $past(scl_in) |->
    $stable(sda_oe)) else $error("data moved with clock high");
  a_drive_is_low: assert property (sda_oe |-> !sda_out)
    else $error("driving data high");
  a_ack_released: assert property ($rose(sda_oe) |->
    ##[1:300] !sda_oe) else $error("data line held");
  a_gain_on_write: assert property ($changed(analog_gain) |->
    !scl_in) else $error("gain moved mid bit");
endmodule // lsc_top_chk
bind lsc_top lsc_top_chk #(.STEP_LEN(STEP_LEN)) u_chk (.sys_clk, .rst,
  .clk_en, .scl_in, .sda_in, .sda_out, .sda_oe, .visible_sample,
  .infrared_sample, .irq_event, .analog_gain, .integrating, .system_state);
`default_nettype wire

// file: tb/lsc_host.sv
// Bus controller model that drives clock and data of the target port.
// Assumes a pulled-up data line; sda_o high releases it.
`timescale 1ns/1ps
`default_nettype none
module lsc_host
(
  input wire logic sys_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_o
);
  int half = 4;
  // ========================================
  // Bit level
  // Both lines idle released so the first start is clean.
  initial
  begin
    scl = 1'b1;
    sda_o = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Data moves one cycle after the clock falls, giving the target hold.
  task automatic bo(input logic b);
    sda_o = b;
    wt(half);
    scl = 1'b1;
    wt(half);
    scl = 1'b0;
    wt(1);
  endtask
  task automatic bi(output logic b);
    sda_o = 1'b1;
    wt(half);
    scl = 1'b1;
    wt(half);
    b = sda_line;
    scl = 1'b0;
    wt(1);
  endtask
  // ========================================
  // Frame level
  // Start also serves as repeated start from a low clock.
  task automatic st();
    sda_o = 1'b1;
    wt(half);
    scl = 1'b1;
    wt(half);
    sda_o = 1'b0;
    wt(half);
    scl = 1'b0;
    wt(1);
  endtask
  task automatic sp();
    sda_o = 1'b0;
    wt(half);
    scl = 1'b1;
    wt(half);
    sda_o = 1'b1;
    wt(half);
  endtask
  task automatic pb(input logic [7:0] b, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--)
      bo(b[i]);
    bi(a);
    ack = !a;
  endtask
  // The last byte of a read is refused so the target lets go.
  task automatic gb(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      bi(d[i]);
    bo(last);
  endtask
endmodule // lsc_host
`default_nettype wire

// file: tb/lsc_top_bench.sv
// Self-checking bench for the light sensor control top.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module lsc_top_bench;
  import lsc_pkg::*;
  typedef logic [7:0] lsc_bq_t[$];
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic scl, sda_o, sda_oe, sda_out, integrating, ak;
  logic irq_event = 1'b0;
  logic clk_en = 1'b1;
  logic [4:0] mon_st = 5'h00;
  logic [7:0] mon_run = 8'h00;
  logic [7:0] az_len = 8'h00;
  logic [7:0] wt_len = 8'h00;
  logic [15:0] vis = 16'h1234;
  logic [15:0] ir = 16'hABCD;
  logic [2:0] gain;
  logic [4:0] st;
  logic [7:0] d;
  int bad_count = 0;
  int cmp_count = 0;
  // Pulled-up data line, low whenever the target drives it.
  wire sda = sda_o & ~sda_oe;
  lsc_top #(.STEP_LEN(4)) u_dut (.sys_clk(sys_clk), .rst(rst),
    .clk_en(clk_en), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .visible_sample(vis), .infrared_sample(ir),
    .irq_event(irq_event), .analog_gain(gain),
    .integrating(integrating), .system_state(st));
  lsc_host u_host (.sys_clk(sys_clk), .sda_line(sda), .scl(scl),
    .sda_o(sda_o));
  // ========================================
  // Clock and tasks
  initial
  begin
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e)
    begin
      bad_count++;
      $display("MISMATCH %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic print_verdict();
    if (bad_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // The address and data bytes of a write must be acknowledged.
  task automatic wr(input logic [7:0] ofs, input lsc_bq_t q);
    u_host.st();
    u_host.pb({TARGET_ADDR, 1'b0}, ak);
    chk({7'h00, ak}, 8'h01);
    u_host.pb(ofs, ak);
    foreach (q[i])
    begin
      u_host.pb(q[i], ak);
      chk({7'h00, ak}, 8'h01);
    end
    u_host.sp();
  endtask
  // A short read skips the pointer byte and reuses the kept pointer.
  task automatic rd(input logic full, input logic [7:0] ofs,
    input lsc_bq_t q);
    if (full)
    begin
      u_host.st();
      u_host.pb({TARGET_ADDR, 1'b0}, ak);
      u_host.pb(ofs, ak);
    end
    u_host.st();
    u_host.pb({TARGET_ADDR, 1'b1}, ak);
    foreach (q[i])
    begin
      u_host.gb(i == q.size() - 1, d);
      chk(d, q[i]);
    end
    u_host.sp();
  endtask
  task automatic wait_st(input logic [4:0] s);
    for (int n = 0; n < 400 && st !== s; n++)
      @(negedge sys_clk);
    chk({3'h0, st}, {3'h0, s});
  endtask
  // Length in cycles of the latest autozero and wait visits. Phases are
  // far shorter than a bus transfer, so they are measured as they pass.
  always @(negedge sys_clk)
  begin
    mon_st <= st;
    mon_run <= (st == mon_st) ? mon_run + 8'h01 : 8'h01;
    if (st != mon_st && mon_st == LSC_AUTOZERO)
      az_len <= mon_run;
    if (st != mon_st && mon_st == LSC_WAIT)
      wt_len <= mon_run;
  end
  // ========================================
  // Scenarios
  initial
  begin
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    chk({3'h0, st}, {3'h0, LSC_SLEEP});
    rd(1, OFS_CONFIG_ZERO, '{RST_CONFIG_ZERO});
    rd(1, OFS_CONFIG_TWO, '{RST_CONFIG_TWO});
    rd(1, OFS_CONFIG_THREE, '{RST_CONFIG_THREE});
    rd(1, OFS_AUTOZERO_CONFIG, '{RST_AUTOZERO_CONFIG});
    rd(1, OFS_REVISION_CODE, '{REVISION_VALUE, PART_VALUE});
    wr(OFS_LOW_THRESHOLD_LO, '{8'h11, 8'h22, 8'h33, 8'h44});
    rd(1, OFS_LOW_THRESHOLD_LO, '{8'h11});
    rd(0, 8'h00, '{8'h22, 8'h33});
    rd(0, 8'h00, '{8'h44});
    wr(OFS_REVISION_CODE, '{8'hAA});
    rd(1, OFS_REVISION_CODE, '{REVISION_VALUE});
    u_host.st();
    u_host.pb({TARGET_ADDR + 7'h01, 1'b0}, ak);
    chk({7'h00, ak}, 8'h00);
    u_host.sp();
    u_host.half = 24;
    for (int g = 0; g < 8; g++)
    begin
      wr(OFS_CONFIG_ONE, '{8'h10 | g[7:0]});
      chk({5'h00, gain}, g[7:0]);
      u_host.half = 4;
    end
    wr(OFS_INTEGRATION_TIME, '{8'h01, 8'h55, 8'h02});
    rd(1, OFS_WAIT_TIME, '{8'h02});
    wr(OFS_FUNCTION_ENABLE, '{8'h01});
    wait_st(LSC_IDLE);
    wr(OFS_FUNCTION_ENABLE, '{8'h00});
    wait_st(LSC_SLEEP);
    wr(OFS_FUNCTION_ENABLE, '{8'h0B});
    wait_st(LSC_INTEGRATE);
    wait_st(LSC_WAIT);
    rd(1, OFS_VISIBLE_RESULT_LO, '{8'h34, 8'h12, 8'hCD, 8'hAB});
    wait_st(LSC_INTEGRATE);
    chk({7'h00, integrating}, 8'h01);
    // Wait is three steps of four cycles with wait_time at 2.
    chk(wt_len, 8'h0C);
    // A low enable must hold the integration past its normal end.
    clk_en = 1'b0;
    repeat (20) @(negedge sys_clk);
    chk({3'h0, st}, {3'h0, LSC_INTEGRATE});
    clk_en = 1'b1;
    // From Idle, a cleared autozero-done flag makes the next autozero
    // pass take two cycles instead of one.
    wr(OFS_FUNCTION_ENABLE, '{8'h01});
    wr(OFS_AUTOZERO_CONFIG, '{8'h05});
    wr(OFS_INTEGRATION_TIME, '{8'h07});
    wr(OFS_FUNCTION_ENABLE, '{8'h03});
    chk(az_len, 8'h02);
    wait_st(LSC_WAIT);
    wait_st(LSC_INTEGRATE);
    @(negedge sys_clk);
    chk(wt_len, 8'h01);
    chk(az_len, 8'h01);
    irq_event = 1'b1;
    wait_st(LSC_SLEEP);
    irq_event = 1'b0;
    repeat (50) @(negedge sys_clk);
    chk({3'h0, st}, {3'h0, LSC_SLEEP});
    rd(1, OFS_DEVICE_STATUS, '{8'h10});
    wr(OFS_DEVICE_STATUS, '{8'h00});
    wait_st(LSC_INTEGRATE);
    print_verdict();
  end
  // Cuts a hang short well past the expected run length.
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    bad_count++;
    print_verdict();
  end
endmodule // lsc_top_bench
`default_nettype wire
